// ===== hdl/anpr_pkg.sv
// register map, field positions and reset values of the autoneg page regs
// assumes a plain register port with a single 16-bit word per address
package anpr_pkg;
	localparam logic [4:0] ANPR_OFS_PARTNER = 5'h05;
	localparam logic [4:0] ANPR_OFS_EXPAN = 5'h06;
	localparam logic [4:0] ANPR_OFS_NEXTPG = 5'h07;
	localparam logic [4:0] ANPR_OFS_IRQ_STAT = 5'h10;
	localparam logic [4:0] ANPR_OFS_IRQ_MASK = 5'h11;
	localparam int ANPR_BIT_NP = 15;
	localparam int ANPR_BIT_ACK = 14;
	localparam int ANPR_BIT_RF = 13;
	localparam int ANPR_BIT_MP = 13;
	localparam int ANPR_BIT_ACK2 = 12;
	localparam int ANPR_BIT_TOG = 11;
	localparam int ANPR_BIT_PDF = 4;
	localparam int ANPR_BIT_LPNP = 3;
	localparam int ANPR_BIT_LDNP = 2;
	localparam int ANPR_BIT_PR = 1;
	localparam int ANPR_BIT_LPAN = 0;
	// partner ability keeps 15..13 and 11..0, bit 12 reserved
	localparam logic [15:0] ANPR_PARTNER_MASK = 16'hEFFF;
	// writable next-page bits: 15, 13, 12, 10:0
	localparam logic [15:0] ANPR_NEXTPG_WMASK = 16'hB7FF;
	localparam logic [15:0] ANPR_NEXTPG_RST = 16'h2001;
	localparam logic [15:0] ANPR_PARTNER_RST = 16'h0000;
	localparam logic [4:0] ANPR_SEL_ETH = 5'h01;
	// irq status bits: 0 page received, 1 parallel fault
	localparam int ANPR_IRQ_PR = 0;
	localparam int ANPR_IRQ_PDF = 1;
endpackage

// ===== hdl/anpr_regs.sv
// partner ability, expansion and local next-page registers
// assumes page events come from the arbitration logic on the same clock
module anpr_regs
	import anpr_pkg::*;
(
	input wire logic CLK_SYS,
	input wire logic RESETN,
	input wire logic [4:0] ADDR,
	input wire logic [15:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [15:0] RDATA,
	input wire logic PAGE_RX,
	input wire logic PAGE_IS_BASE,
	input wire logic [15:0] PAGE_WORD,
	input wire logic PAR_DET_FAULT,
	input wire logic PARTNER_AN_ABLE,
	input wire logic NP_SENT,
	input wire logic NP_SENT_TOGGLE,
	output logic [15:0] NP_WORD,
	output logic IRQ
);
	logic [15:0] partner, next_partner;
	logic [15:0] nextpg, next_nextpg;
	logic pdf, next_pdf, pr, next_pr, tog, next_tog;
	logic [1:0] istat, next_istat, imask, next_imask;
	logic [15:0] rdata, next_rdata;
	logic [15:0] expan;

	// helper that decides whether an access hits a given register; the read and write cases compare ADDR directly
	function automatic logic addr_hit(input logic [4:0] a,
		input logic [4:0] ofs);
		addr_hit = (a == ofs);
	endfunction

	// expansion view, bit 2 tied high, bit 3 from partner base page
	always_comb begin
		expan = 16'h0000;
		expan[ANPR_BIT_PDF] = pdf;
		expan[ANPR_BIT_LPNP] = partner[ANPR_BIT_NP];
		expan[ANPR_BIT_LDNP] = 1'b1;
		expan[ANPR_BIT_PR] = pr;
		expan[ANPR_BIT_LPAN] = PARTNER_AN_ABLE;
	end

	// next state of all registers; events win over read-clear
	always_comb begin
		next_partner = partner;
		next_nextpg = nextpg;
		next_pdf = pdf;
		next_pr = pr;
		next_tog = tog;
		next_istat = istat;
		next_imask = imask;
		next_rdata = 16'h0000;
		if (PAGE_RX && PAGE_IS_BASE)
			next_partner = PAGE_WORD & ANPR_PARTNER_MASK;
		if (NP_SENT)
			next_tog = ~NP_SENT_TOGGLE;
		if (RD) begin
			case (ADDR)
				ANPR_OFS_PARTNER: next_rdata = partner;
				ANPR_OFS_EXPAN: next_rdata = expan;
				ANPR_OFS_NEXTPG: next_rdata = NP_WORD;
				ANPR_OFS_IRQ_STAT: next_rdata = {14'h0000, istat};
				ANPR_OFS_IRQ_MASK: next_rdata = {14'h0000, imask};
				default: next_rdata = 16'h0000;
			endcase
			if (addr_hit(ADDR, ANPR_OFS_EXPAN)) begin
				next_pdf = 1'b0;
				next_pr = 1'b0;
			end
		end
		if (WR) begin
			case (ADDR)
				ANPR_OFS_NEXTPG: next_nextpg = WDATA & ANPR_NEXTPG_WMASK;
				ANPR_OFS_IRQ_STAT: next_istat = istat & ~WDATA[1:0];
				ANPR_OFS_IRQ_MASK: next_imask = WDATA[1:0];
				default: next_imask = imask;
			endcase
		end
		if (PAR_DET_FAULT) begin
			next_pdf = 1'b1;
			next_istat[ANPR_IRQ_PDF] = 1'b1;
		end
		if (PAGE_RX) begin
			next_pr = 1'b1;
			next_istat[ANPR_IRQ_PR] = 1'b1;
		end
	end

	// registers; reset clears latched bits and loads the null message
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			partner <= ANPR_PARTNER_RST;
			nextpg <= ANPR_NEXTPG_RST;
			pdf <= 1'b0;
			pr <= 1'b0;
			tog <= 1'b0;
			istat <= 2'h0;
			imask <= 2'h0;
			rdata <= 16'h0000;
		end else begin
			partner <= next_partner;
			nextpg <= next_nextpg;
			pdf <= next_pdf;
			pr <= next_pr;
			tog <= next_tog;
			istat <= next_istat;
			imask <= next_imask;
			rdata <= next_rdata;
		end
	end

	// toggle is merged live so the word sent always carries it
	always_comb begin
		NP_WORD = nextpg;
		NP_WORD[ANPR_BIT_TOG] = tog;
	end
	assign RDATA = rdata;
	assign IRQ = |(istat & imask);

	a_partner_update: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		PAGE_RX && PAGE_IS_BASE |=> partner == ($past(PAGE_WORD) & ANPR_PARTNER_MASK))
		else $error("partner ability not captured");
	a_partner_hold: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		!(PAGE_RX && PAGE_IS_BASE) |=> $stable(partner))
		else $error("partner ability changed without page");
	a_pdf_latch: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		PAR_DET_FAULT ##1 RD && ADDR == ANPR_OFS_EXPAN |=> RDATA[ANPR_BIT_PDF])
		else $error("parallel fault not latched");
	a_pr_clear: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		RD && ADDR == ANPR_OFS_EXPAN && !PAGE_RX ##1 RD && ADDR == ANPR_OFS_EXPAN
		&& !PAGE_RX |=> !RDATA[ANPR_BIT_PR])
		else $error("page received not cleared by read");
	a_pr_latch: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		PAGE_RX |=> pr)
		else $error("page received lost");
	a_local_np: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		RD && ADDR == ANPR_OFS_EXPAN |=> RDATA[ANPR_BIT_LDNP])
		else $error("local next page bit not one");
	a_toggle_inv: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		NP_SENT |=> NP_WORD[ANPR_BIT_TOG] != $past(NP_SENT_TOGGLE))
		else $error("toggle not inverted");
	a_np_write: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		WR && ADDR == ANPR_OFS_NEXTPG |=> (NP_WORD & ANPR_NEXTPG_WMASK)
		== ($past(WDATA) & ANPR_NEXTPG_WMASK))
		else $error("next page write not taken");
	a_lp_np: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		PAGE_RX && PAGE_IS_BASE
		|=> expan[ANPR_BIT_LPNP] == $past(PAGE_WORD[ANPR_BIT_NP]))
		else $error("partner next page ability wrong");

	// read data only in the cycle after a read, zero otherwise
	a_rdata_quiet: assert property (@(posedge CLK_SYS)
		disable iff (!RESETN)
		!RD |=> RDATA == 16'h0000)
		else $error("read data not zero when idle");

	// partner ability read returns the stored word
	a_partner_read: assert property (@(posedge CLK_SYS)
		disable iff (!RESETN)
		RD && addr_hit(ADDR, ANPR_OFS_PARTNER) |=> RDATA == $past(partner))
		else $error("partner ability read wrong");

	// reserved partner bit never reads one
	a_partner_rsvd: assert property (@(posedge CLK_SYS)
		disable iff (!RESETN)
		RD && addr_hit(ADDR, ANPR_OFS_PARTNER) |=> !RDATA[12])
		else $error("partner reserved bit set");

	// next-page request bit follows the base page
	a_partner_np: assert property (@(posedge CLK_SYS)
		disable iff (!RESETN)
		PAGE_RX && PAGE_IS_BASE
		|=> ((partner ^ $past(PAGE_WORD)) & 16'h8000) == 16'h0000)
		else $error("partner next page bit wrong");

	// acknowledge bit follows the base page
	a_partner_ack: assert property (@(posedge CLK_SYS)
		disable iff (!RESETN)
		PAGE_RX && PAGE_IS_BASE
		|=> ((partner ^ $past(PAGE_WORD)) & 16'h4000) == 16'h0000)
		else $error("partner acknowledge bit wrong");

	// remote fault bit follows the base page
	a_partner_rf: assert property (@(posedge CLK_SYS)
		disable iff (!RESETN)
		PAGE_RX && PAGE_IS_BASE
		|=> ((partner ^ $past(PAGE_WORD)) & 16'h2000) == 16'h0000)
		else $error("partner remote fault bit wrong");

	// both pause bits follow the base page
	a_partner_pause: assert property (@(posedge CLK_SYS)
		disable iff (!RESETN)
		PAGE_RX && PAGE_IS_BASE
		|=> ((partner ^ $past(PAGE_WORD)) & 16'h0C00) == 16'h0000)
		else $error("partner pause bits wrong");

	// technology abilities follow the base page
	a_partner_tech: assert property (@(posedge CLK_SYS)
		disable iff (!RESETN)
		PAGE_RX && PAGE_IS_BASE
		|=> ((partner ^ $past(PAGE_WORD)) & 16'h03E0) == 16'h0000)
		else $error("partner technology bits wrong");

	// selector field follows the base page
	a_partner_sel: assert property (@(posedge CLK_SYS)
		disable iff (!RESETN)
		PAGE_RX && PAGE_IS_BASE
		|=> ((partner ^ $past(PAGE_WORD)) & 16'h001F) == 16'h0000)
		else $error("partner selector wrong");

	// upper expansion bits are reserved
	a_expan_rsvd: assert property (@(posedge CLK_SYS)
		disable iff (!RESETN)
		RD && addr_hit(ADDR, ANPR_OFS_EXPAN) |=> RDATA[15:5] == 11'h000)
		else $error("expansion reserved bits set");

	// partner autoneg ability is shown live
	a_expan_lpan: assert property (@(posedge CLK_SYS)
		disable iff (!RESETN)
		RD && addr_hit(ADDR, ANPR_OFS_EXPAN)
		|=> RDATA[ANPR_BIT_LPAN] == $past(PARTNER_AN_ABLE))
		else $error("partner autoneg ability wrong");

	// partner next-page ability as read
	a_expan_lpnp: assert property (@(posedge CLK_SYS)
		disable iff (!RESETN)
		RD && addr_hit(ADDR, ANPR_OFS_EXPAN)
		|=> RDATA[ANPR_BIT_LPNP] == $past(partner[ANPR_BIT_NP]))
		else $error("partner next page ability read wrong");

	// a fault always latches, whatever else happens
	a_pdf_set: assert property (@(posedge CLK_SYS)
		disable iff (!RESETN)
		PAR_DET_FAULT |=> pdf)
		else $error("parallel fault not set");

	// latched fault survives anything but an expansion read
	a_pdf_hold: assert property (@(posedge CLK_SYS)
		disable iff (!RESETN)
		pdf && !(RD && addr_hit(ADDR, ANPR_OFS_EXPAN)) |=> pdf)
		else $error("parallel fault lost");

	// fault bit never rises without an event
	a_pdf_no_event: assert property (@(posedge CLK_SYS)
		disable iff (!RESETN)
		!pdf && !PAR_DET_FAULT |=> !pdf)
		else $error("parallel fault set without event");

	// expansion read clears the fault bit
	a_pdf_read_clr: assert property (@(posedge CLK_SYS)
		disable iff (!RESETN)
		RD && addr_hit(ADDR, ANPR_OFS_EXPAN) && !PAR_DET_FAULT |=> !pdf)
		else $error("parallel fault not cleared by read");

	// latched page flag survives anything but an expansion read
	a_pr_hold: assert property (@(posedge CLK_SYS)
		disable iff (!RESETN)
		pr && !(RD && addr_hit(ADDR, ANPR_OFS_EXPAN)) |=> pr)
		else $error("page received lost");

	// page flag never rises without a page
	a_pr_no_event: assert property (@(posedge CLK_SYS)
		disable iff (!RESETN)
		!pr && !PAGE_RX |=> !pr)
		else $error("page received without page");

	// expansion read clears the page flag
	a_pr_read_clr: assert property (@(posedge CLK_SYS)
		disable iff (!RESETN)
		RD && addr_hit(ADDR, ANPR_OFS_EXPAN) && !PAGE_RX |=> !pr)
		else $error("page received not cleared");

	// next-page read returns the word being sent
	a_np_read: assert property (@(posedge CLK_SYS)
		disable iff (!RESETN)
		RD && addr_hit(ADDR, ANPR_OFS_NEXTPG) |=> RDATA == $past(NP_WORD))
		else $error("next page read wrong");

	// reserved next-page bit stays zero
	a_np_rsvd: assert property (@(posedge CLK_SYS)
		disable iff (!RESETN)
		!NP_WORD[14])
		else $error("next page reserved bit set");

	// next-page bit 15 written as given
	a_np_more: assert property (@(posedge CLK_SYS)
		disable iff (!RESETN)
		WR && addr_hit(ADDR, ANPR_OFS_NEXTPG)
		|=> nextpg[ANPR_BIT_NP] == $past(WDATA[ANPR_BIT_NP]))
		else $error("next page more bit wrong");

	// message page select written as given
	a_np_mp_write: assert property (@(posedge CLK_SYS)
		disable iff (!RESETN)
		WR && addr_hit(ADDR, ANPR_OFS_NEXTPG)
		|=> nextpg[ANPR_BIT_MP] == $past(WDATA[ANPR_BIT_MP]))
		else $error("message page bit wrong");

	// comply flag written as given
	a_np_ack2_write: assert property (@(posedge CLK_SYS)
		disable iff (!RESETN)
		WR && addr_hit(ADDR, ANPR_OFS_NEXTPG)
		|=> nextpg[ANPR_BIT_ACK2] == $past(WDATA[ANPR_BIT_ACK2]))
		else $error("comply bit wrong");

	// code field written as given
	a_np_code_write: assert property (@(posedge CLK_SYS)
		disable iff (!RESETN)
		WR && addr_hit(ADDR, ANPR_OFS_NEXTPG)
		|=> nextpg[10:0] == $past(WDATA[10:0]))
		else $error("next page code wrong");

	// next-page word only changes on a write to it
	a_np_hold: assert property (@(posedge CLK_SYS)
		disable iff (!RESETN)
		!(WR && addr_hit(ADDR, ANPR_OFS_NEXTPG)) |=> $stable(nextpg))
		else $error("next page word changed unasked");

	// toggle only moves when a page is exchanged
	a_tog_hold: assert property (@(posedge CLK_SYS)
		disable iff (!RESETN)
		!NP_SENT |=> $stable(tog))
		else $error("toggle moved without exchange");

	// unmasked page event raises the interrupt
	a_irq_page: assert property (@(posedge CLK_SYS)
		disable iff (!RESETN)
		PAGE_RX && imask[ANPR_IRQ_PR]
		&& !(WR && addr_hit(ADDR, ANPR_OFS_IRQ_MASK)) |=> IRQ)
		else $error("page interrupt missing");

	// unmasked fault event raises the interrupt
	a_irq_fault: assert property (@(posedge CLK_SYS)
		disable iff (!RESETN)
		PAR_DET_FAULT && imask[ANPR_IRQ_PDF]
		&& !(WR && addr_hit(ADDR, ANPR_OFS_IRQ_MASK)) |=> IRQ)
		else $error("fault interrupt missing");

	// fully masked status never interrupts
	a_irq_masked: assert property (@(posedge CLK_SYS)
		disable iff (!RESETN)
		imask == 2'h0 |-> !IRQ)
		else $error("interrupt while masked");

	// write one clears a status bit when no event competes
	a_stat_w1c: assert property (@(posedge CLK_SYS)
		disable iff (!RESETN)
		WR && addr_hit(ADDR, ANPR_OFS_IRQ_STAT) && !PAGE_RX && !PAR_DET_FAULT
		|=> ({14'h0000, istat} & $past(WDATA)) == 16'h0000)
		else $error("status bit not cleared");

	// status read returns the sticky bits
	a_stat_read: assert property (@(posedge CLK_SYS)
		disable iff (!RESETN)
		RD && addr_hit(ADDR, ANPR_OFS_IRQ_STAT)
		|=> RDATA == {14'h0000, $past(istat)})
		else $error("status read wrong");

	// mask write lands as given
	a_mask_write: assert property (@(posedge CLK_SYS)
		disable iff (!RESETN)
		WR && addr_hit(ADDR, ANPR_OFS_IRQ_MASK) |=> imask == $past(WDATA[1:0]))
		else $error("mask write wrong");

	// mask read returns the mask
	a_mask_read: assert property (@(posedge CLK_SYS)
		disable iff (!RESETN)
		RD && addr_hit(ADDR, ANPR_OFS_IRQ_MASK)
		|=> RDATA == {14'h0000, $past(imask)})
		else $error("mask read wrong");

	// unmapped addresses read zero
	a_unmapped_read: assert property (@(posedge CLK_SYS)
		disable iff (!RESETN)
		RD && ADDR != ANPR_OFS_PARTNER && ADDR != ANPR_OFS_EXPAN
		&& ADDR != ANPR_OFS_NEXTPG && ADDR != ANPR_OFS_IRQ_STAT
		&& ADDR != ANPR_OFS_IRQ_MASK |=> RDATA == 16'h0000)
		else $error("unmapped read not zero");

	c_base_page: cover property (@(posedge CLK_SYS) PAGE_RX && PAGE_IS_BASE);
	c_pdf_read: cover property (@(posedge CLK_SYS) PAR_DET_FAULT ##1 RD);
	c_np_write: cover property (@(posedge CLK_SYS) WR && ADDR == ANPR_OFS_NEXTPG);
	c_irq: cover property (@(posedge CLK_SYS) IRQ);
	c_np_sent: cover property (@(posedge CLK_SYS) NP_SENT);
endmodule

// ===== tb/anpr_partner.sv
// remote link partner model: pages, next-page exchange, faults
// assumes the bench calls its tasks from one process only
module anpr_partner (
	input wire logic clk,
	output logic rx,
	output logic base,
	output logic [15:0] word,
	output logic fault,
	output logic sent,
	output logic tog
);
	timeunit 1ns;
	timeprecision 1ns;
	initial {rx, base, word, fault, sent, tog} = '0;
	// word is scrambled after the strobe so stale data cannot pass
	task page(input logic b, input logic [15:0] w);
		@(posedge clk);
		rx <= 1'b1;
		base <= b;
		word <= w;
		@(posedge clk);
		rx <= 1'b0;
		word <= ~w;
	endtask
	// one next page exchanged, carrying toggle t
	task xchg(input logic t);
		@(posedge clk);
		sent <= 1'b1;
		tog <= t;
		@(posedge clk);
		sent <= 1'b0;
	endtask
	task pdf;
		@(posedge clk);
		fault <= 1'b1;
		@(posedge clk);
		fault <= 1'b0;
	endtask
endmodule

// ===== tb/autoneg_partner_nextpage_regs_test.sv
// self-checking bench for the autoneg page registers
// assumes a 10 MHz clock and the partner model for page events
module autoneg_partner_nextpage_regs_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, resetn = 0, wr = 0, rd = 0, an = 0;
	logic [4:0] addr = '0;
	logic [15:0] wdata = '0, rdata, np_word, word;
	logic irq, rx, base, fault, sent, tog;
	logic [15:0] pg [2] = '{16'hFFFF, 16'h4C21};
	int miscompares = 0, num_checks = 0, cyc = 0;
	anpr_regs DUT (.CLK_SYS(clk), .RESETN(resetn), .ADDR(addr),
		.WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .PAGE_RX(rx),
		.PAGE_IS_BASE(base), .PAGE_WORD(word), .PAR_DET_FAULT(fault),
		.PARTNER_AN_ABLE(an), .NP_SENT(sent), .NP_SENT_TOGGLE(tog),
		.NP_WORD(np_word), .IRQ(irq));
	anpr_partner lp (.clk(clk), .rx(rx), .base(base), .word(word),
		.fault(fault), .sent(sent), .tog(tog));
	initial forever #50 clk = ~clk;
	task chk(input logic [15:0] g, input logic [15:0] e);
		num_checks++;
		if (g !== e) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task wrr(input logic [4:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask
	// read data stand only in the cycle after the strobe
	task rdc(input logic [4:0] a, input logic [15:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(rdata, e);
	endtask
	task results;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// hang guard, well above the roughly 70 cycles needed
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			miscompares++;
			results();
		end
	end
	initial begin
		repeat (10) @(posedge clk);
		chk(np_word & 16'hF7FF, 16'h2001);
		resetn <= 1'b1;
		rdc(5'h05, 16'h0000);
		rdc(5'h06, 16'h0004);
		rdc(5'h1F, 16'h0000);
		an <= 1'b1;
		wrr(5'h11, 16'h0003);
		foreach (pg[i]) begin
			lp.page(1'b1, pg[i]);
			#1 chk({15'h0, irq}, 16'h0001);
			rdc(5'h05, pg[i] & 16'hEFFF);
			rdc(5'h06, {12'h0, pg[i][15], 3'h7});
			rdc(5'h06, {12'h0, pg[i][15], 3'h5});
			wrr(5'h10, 16'h0001);
			chk({15'h0, irq}, 16'h0000);
		end
		// masked event must not raise the interrupt
		wrr(5'h11, 16'h0000);
		lp.page(1'b0, 16'h1234);
		#1 chk({15'h0, irq}, 16'h0000);
		rdc(5'h05, 16'h4C21);
		rdc(5'h06, 16'h0007);
		lp.pdf();
		rdc(5'h06, 16'h0015);
		rdc(5'h06, 16'h0005);
		rdc(5'h10, 16'h0003);
		wrr(5'h11, 16'h0002);
		chk({15'h0, irq}, 16'h0001);
		rdc(5'h11, 16'h0002);
		wrr(5'h10, 16'h0003);
		rdc(5'h10, 16'h0000);
		chk({15'h0, irq}, 16'h0000);
		lp.xchg(1'b1);
		wrr(5'h07, 16'hFFFF);
		chk(np_word, 16'hB7FF);
		rdc(5'h07, 16'hB7FF);
		lp.xchg(1'b0);
		#1 chk(np_word, 16'hBFFF);
		wrr(5'h07, 16'h0000);
		chk(np_word, 16'h0800);
		results();
	end
endmodule
